/* File: design/irdct_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "irdct_consts.vh"
module irdct_top
(
   // clock and reset
   input wire clk_in,
   input wire arst_n_in,
   // register port
   input wire [7:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [7:0] rdata_out,
   // link pins
   input wire demod_a_in,
   input wire demod_b_in,
   output reg ir_out,
   // events
   output reg capture_irq_out,
   output reg timeout_out
);
   // ----------------------------------------
   // reset release
   // ----------------------------------------
   reg rst_s1;
   reg rst_n;
   always @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg run8, single8, tmo8, capie;
   reg [1:0] pre_sel;
   reg mode_demod, pin_sel;
   reg [1:0] cmb, sub;
   reg init8, init16;
   reg rise_flag, fall_flag;
   reg run16, single16, tmo16;
   reg [7:0] hold_low, hold_high, hold_wlo, hold_whi;
   reg [7:0] cap_lo, cap_hi;
   reg [7:0] cnt8;
   reg [15:0] cnt16;
   reg out8, out16;
   reg demod_active;
   reg pp_turn16;
   // stop and clear requests wait for the next timer tick
   reg pend_stop8, pend_clr_tmo, pend_clr_rise, pend_clr_fall;
   wire tick;
   wire wr_ctl8 = wr_in && addr_in == `IRDCT_ADDR_CTL8;
   wire wr_sh = wr_in && addr_in == `IRDCT_ADDR_SHARED;
   wire wr_ctl16 = wr_in && addr_in == `IRDCT_ADDR_CTL16;

   // ----------------------------------------
   // input synchroniser and filter
   // ----------------------------------------
   reg [1:0] a_sync, b_sync;
   always @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         a_sync <= 2'h0;
         b_sync <= 2'h0;
      end
      else
      begin
         a_sync <= {a_sync[0], demod_a_in};
         b_sync <= {b_sync[0], demod_b_in};
      end
   end
   wire demod_raw = pin_sel ? b_sync[1] : a_sync[1];
   wire demod_f;
   reg demod_prev;
   irdct_glitch_filter u_filter
   (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .width_sel_in(sub),
      .sig_in(demod_raw),
      .sig_out(demod_f)
   );
   irdct_prescaler u_pre
   (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .div_sel_in(pre_sel),
      .tick_out(tick)
   );

   wire rise_ev = mode_demod && demod_f && !demod_prev;
   wire fall_ev = mode_demod && !demod_f && demod_prev;
   reg edge_hit;
   always @*
   begin
      case (cmb)
         `IRDCT_EDGE_FALL: edge_hit = fall_ev;
         `IRDCT_EDGE_RISE: edge_hit = rise_ev;
         `IRDCT_EDGE_BOTH: edge_hit = rise_ev || fall_ev;
         default: edge_hit = 1'b0;
      endcase
   end

   // ----------------------------------------
   // register writes and flags
   // ----------------------------------------
   wire tmo8_set;
   always @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         run8 <= 1'b0; single8 <= 1'b0; tmo8 <= 1'b0; capie <= 1'b0;
         pre_sel <= 2'h0; mode_demod <= 1'b0; pin_sel <= 1'b0;
         cmb <= `IRDCT_CMB_AND;
         sub <= `IRDCT_SUB_NORMAL;
         init8 <= 1'b0; init16 <= 1'b0;
         rise_flag <= 1'b0; fall_flag <= 1'b0;
         run16 <= 1'b0; single16 <= 1'b0;
         hold_low <= `IRDCT_RST_BYTE; hold_high <= `IRDCT_RST_BYTE;
         hold_wlo <= `IRDCT_RST_BYTE; hold_whi <= `IRDCT_RST_BYTE;
         pend_stop8 <= 1'b0; pend_clr_tmo <= 1'b0;
         pend_clr_rise <= 1'b0; pend_clr_fall <= 1'b0;
         demod_prev <= 1'b0;
      end
      else
      begin
         demod_prev <= demod_f;
         if (wr_ctl8)
         begin
            single8 <= wdata_in[`IRDCT_B_SINGLE];
            pre_sel <= wdata_in[`IRDCT_B_PRE_HI:`IRDCT_B_PRE_LO];
            capie <= wdata_in[`IRDCT_B_CAPIE];
            if (wdata_in[`IRDCT_B_RUN])
            begin
               run8 <= 1'b1;
               pend_stop8 <= 1'b0; // a fresh start cancels a stop still waiting
            end
            else if (run8)
               pend_stop8 <= 1'b1;
            if (wdata_in[`IRDCT_B_TMO])
               pend_clr_tmo <= 1'b1;
         end
         else if (tick)
         begin
            if (pend_stop8)
               run8 <= 1'b0;
            pend_stop8 <= 1'b0;
            pend_clr_tmo <= 1'b0;
            pend_clr_rise <= 1'b0;
            pend_clr_fall <= 1'b0;
         end
         if (wr_sh)
         begin
            mode_demod <= wdata_in[`IRDCT_B_MODE];
            pin_sel <= wdata_in[`IRDCT_B_PINSEL];
            cmb <= wdata_in[`IRDCT_B_CMB_HI:`IRDCT_B_CMB_LO];
            sub <= wdata_in[`IRDCT_B_SUB_HI:`IRDCT_B_SUB_LO];
            if (!wdata_in[`IRDCT_B_MODE])
            begin
               init8 <= wdata_in[`IRDCT_B_INIT8];
               init16 <= wdata_in[`IRDCT_B_INIT16];
            end
            if (wdata_in[`IRDCT_B_INIT8])
               pend_clr_rise <= 1'b1;
            if (wdata_in[`IRDCT_B_INIT16])
               pend_clr_fall <= 1'b1;
         end
         // set wins over a pending clear
         if (rise_ev)
            rise_flag <= 1'b1;
         else if (tick && pend_clr_rise && !wr_ctl8)
            rise_flag <= 1'b0;
         if (fall_ev)
            fall_flag <= 1'b1;
         else if (tick && pend_clr_fall && !wr_ctl8)
            fall_flag <= 1'b0;
         if (tmo8_set)
            tmo8 <= 1'b1;
         else if (tick && pend_clr_tmo && !wr_ctl8)
            tmo8 <= 1'b0;
         if (wr_ctl16)
         begin
            run16 <= wdata_in[`IRDCT_B_RUN16];
            single16 <= wdata_in[`IRDCT_B_SINGLE16];
         end
         else if (tmo16 && single16)
            run16 <= 1'b0;
         if (wr_in && addr_in == `IRDCT_ADDR_LOW) hold_low <= wdata_in;
         if (wr_in && addr_in == `IRDCT_ADDR_HIGH) hold_high <= wdata_in;
         if (wr_in && addr_in == `IRDCT_ADDR_W_LO) hold_wlo <= wdata_in;
         if (wr_in && addr_in == `IRDCT_ADDR_W_HI) hold_whi <= wdata_in;
      end
   end

   // ----------------------------------------
   // eight-bit timer
   // ----------------------------------------
   reg run8_d;
   wire pp_mode = !mode_demod && sub == `IRDCT_SUB_PINGPONG;
   wire t8_go = run8 && (!pp_mode || !pp_turn16);
   wire [7:0] reload8 = out8 ? hold_high : hold_low;
   assign tmo8_set = tick && t8_go && run8_d && !mode_demod && cnt8 == 8'h01;
   always @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt8 <= `IRDCT_RST_BYTE; out8 <= 1'b1; run8_d <= 1'b0;
         demod_active <= 1'b0; cap_lo <= `IRDCT_RST_BYTE;
         cap_hi <= `IRDCT_RST_BYTE; capture_irq_out <= 1'b0;
         pp_turn16 <= 1'b0; timeout_out <= 1'b0;
      end
      else
      begin
         run8_d <= run8;
         capture_irq_out <= 1'b0;
         timeout_out <= tmo8_set;
         if (!run8)
         begin
            out8 <= !init8;
            demod_active <= 1'b0;
            pp_turn16 <= 1'b0;
         end
         else if (mode_demod)
         begin
            if (edge_hit && !demod_active)
            begin
               demod_active <= 1'b1;
               cnt8 <= hold_low;
            end
            else if (edge_hit)
            begin
               if (rise_ev)
                  cap_hi <= ~cnt8;
               else
                  cap_lo <= ~cnt8;
               capture_irq_out <= capie;
               cnt8 <= hold_low;
            end
            else if (demod_active && tick)
               cnt8 <= cnt8 - 8'h01; // wrap to ff is no timeout
         end
         else if (!run8_d || (pp_mode && pp_turn16 && tmo16))
         begin
            out8 <= init8;
            cnt8 <= init8 ? hold_high : hold_low;
            pp_turn16 <= 1'b0;
         end
         else if (t8_go && tick)
         begin
            if (cnt8 == 8'h01)
            begin
               // only the 1 to 0 step is a timeout, never 0 to ff
               out8 <= !out8;
               cnt8 <= !out8 ? hold_high : hold_low;
               if (pp_mode)
                  pp_turn16 <= 1'b1;
            end
            else
               cnt8 <= cnt8 - 8'h01;
         end
         if (!pp_mode)
            pp_turn16 <= 1'b0; // normal ends ping-pong
      end
   end

   // ----------------------------------------
   // sixteen-bit timer
   // ----------------------------------------
   reg run16_d;
   wire t16_go = run16 && (!pp_mode || pp_turn16);
   always @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt16 <= 16'h0000; out16 <= 1'b1; run16_d <= 1'b0; tmo16 <= 1'b0;
      end
      else
      begin
         run16_d <= run16;
         tmo16 <= 1'b0;
         if (!mode_demod && sub == `IRDCT_SUB_FORCE0)
            out16 <= 1'b0;
         else if (!mode_demod && sub == `IRDCT_SUB_FORCE1)
            out16 <= 1'b1;
         else if (!run16)
            out16 <= !init16;
         else if (!run16_d)
         begin
            out16 <= init16;
            cnt16 <= {hold_whi, hold_wlo};
         end
         else if (t16_go && tick)
         begin
            if (cnt16 == 16'h0001)
            begin
               out16 <= !out16;
               tmo16 <= 1'b1;
               cnt16 <= {hold_whi, hold_wlo};
            end
            else
               cnt16 <= cnt16 - 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // output combine and readback
   // ----------------------------------------
   reg comb;
   always @*
   begin
      case (cmb)
         `IRDCT_CMB_AND: comb = out8 & out16;
         `IRDCT_CMB_OR: comb = out8 | out16;
         `IRDCT_CMB_NOR: comb = ~(out8 | out16);
         default: comb = ~(out8 & out16);
      endcase
   end

   always @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ir_out <= 1'b0;
         rdata_out <= `IRDCT_RST_BYTE;
      end
      else
      begin
         ir_out <= mode_demod ? 1'b0 : comb;
         if (rd_in)
         begin
            case (addr_in)
               `IRDCT_ADDR_CTL8: rdata_out <= {run8, single8, tmo8, pre_sel, capie, 2'h0};
               `IRDCT_ADDR_SHARED: rdata_out <= {mode_demod, pin_sel, cmb, sub,
                  mode_demod ? rise_flag : init8, mode_demod ? fall_flag : init16};
               `IRDCT_ADDR_CTL16: rdata_out <= {run16, single16, 6'h00};
               `IRDCT_ADDR_LOW: rdata_out <= hold_low;
               `IRDCT_ADDR_HIGH: rdata_out <= hold_high;
               `IRDCT_ADDR_W_LO: rdata_out <= hold_wlo;
               `IRDCT_ADDR_W_HI: rdata_out <= hold_whi;
               `IRDCT_ADDR_CAP_LO: rdata_out <= cap_lo;
               `IRDCT_ADDR_CAP_HI: rdata_out <= cap_hi;
               `IRDCT_ADDR_STATUS: rdata_out <= {demod_active, out8, out16, 5'h00};
               default: rdata_out <= `IRDCT_RST_BYTE;
            endcase
         end
         else
            rdata_out <= `IRDCT_RST_BYTE;
      end
   end
endmodule // irdct_top
`default_nettype wire

/* File: design/irdct_consts.vh */
`ifndef IRDCT_CONSTS_VH
`define IRDCT_CONSTS_VH
// register offsets
`define IRDCT_ADDR_CTL8 8'h00
`define IRDCT_ADDR_SHARED 8'h01
`define IRDCT_ADDR_CTL16 8'h02
`define IRDCT_ADDR_LOW 8'h04
`define IRDCT_ADDR_HIGH 8'h05
`define IRDCT_ADDR_W_LO 8'h06
`define IRDCT_ADDR_W_HI 8'h07
`define IRDCT_ADDR_CAP_LO 8'h08
`define IRDCT_ADDR_CAP_HI 8'h09
`define IRDCT_ADDR_STATUS 8'h0a
// eight-bit control fields
`define IRDCT_B_RUN 7
`define IRDCT_B_SINGLE 6
`define IRDCT_B_TMO 5
`define IRDCT_B_PRE_HI 4
`define IRDCT_B_PRE_LO 3
`define IRDCT_B_CAPIE 2
// shared control fields
`define IRDCT_B_MODE 7
`define IRDCT_B_PINSEL 6
`define IRDCT_B_CMB_HI 5
`define IRDCT_B_CMB_LO 4
`define IRDCT_B_SUB_HI 3
`define IRDCT_B_SUB_LO 2
`define IRDCT_B_INIT8 1
`define IRDCT_B_INIT16 0
// wide control fields
`define IRDCT_B_RUN16 7
`define IRDCT_B_SINGLE16 6
// combine codes
`define IRDCT_CMB_AND 2'h0
`define IRDCT_CMB_OR 2'h1
`define IRDCT_CMB_NOR 2'h2
`define IRDCT_CMB_NAND 2'h3
// edge codes
`define IRDCT_EDGE_FALL 2'h0
`define IRDCT_EDGE_RISE 2'h1
`define IRDCT_EDGE_BOTH 2'h2
// submode codes
`define IRDCT_SUB_NORMAL 2'h0
`define IRDCT_SUB_PINGPONG 2'h1
`define IRDCT_SUB_FORCE0 2'h2
`define IRDCT_SUB_FORCE1 2'h3
// filter codes and widths
`define IRDCT_FLT_NONE 2'h0
`define IRDCT_FLT_4 2'h1
`define IRDCT_FLT_8 2'h2
`define IRDCT_FLT_LEN4 4'h4
`define IRDCT_FLT_LEN8 4'h8
// reset values
`define IRDCT_RST_BYTE 8'h00
`define IRDCT_ALL_ONES 8'hff
`endif

/* File: design/irdct_glitch_filter.v */
`timescale 1ns/1ps
`default_nettype none
`include "irdct_consts.vh"
module irdct_glitch_filter
(
   // clock and reset
   input wire clk_in,
   input wire rst_n_in,
   // control
   input wire [1:0] width_sel_in,
   // signal
   input wire sig_in,
   output reg sig_out
);
   reg [3:0] stable_cnt;
   reg last;
   reg [3:0] need;

   always @*
   begin
      case (width_sel_in)
         `IRDCT_FLT_4: need = `IRDCT_FLT_LEN4;
         `IRDCT_FLT_8: need = `IRDCT_FLT_LEN8;
         default: need = 4'h0;
      endcase
   end

   // a level must hold for the full width before it is passed on
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         stable_cnt <= 4'h0;
         last <= 1'b0;
         sig_out <= 1'b0;
      end
      else
      begin
         last <= sig_in;
         if (sig_in != last)
            stable_cnt <= 4'h1;
         else if (stable_cnt != 4'hf)
            stable_cnt <= stable_cnt + 4'h1;
         if (need == 4'h0 || (sig_in == last && stable_cnt >= need - 4'h1))
            sig_out <= sig_in;
      end
   end
endmodule // irdct_glitch_filter
`default_nettype wire

/* File: design/irdct_prescaler.v */
`timescale 1ns/1ps
`default_nettype none
`include "irdct_consts.vh"
module irdct_prescaler
(
   // clock and reset
   input wire clk_in,
   input wire rst_n_in,
   // control
   input wire [1:0] div_sel_in,
   // tick
   output reg tick_out
);
   reg [2:0] div_cnt;
   reg [2:0] div_max;

   always @*
   begin
      case (div_sel_in)
         2'h1: div_max = 3'h1;
         2'h2: div_max = 3'h3;
         2'h3: div_max = 3'h7;
         default: div_max = 3'h0;
      endcase
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         div_cnt <= 3'h0;
         tick_out <= 1'b0;
      end
      else if (div_cnt >= div_max)
      begin
         div_cnt <= 3'h0;
         tick_out <= 1'b1;
      end
      else
      begin
         div_cnt <= div_cnt + 3'h1;
         tick_out <= 1'b0;
      end
   end
endmodule // irdct_prescaler
`default_nettype wire

/* File: dv/irdct_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "irdct_consts.vh"
module irdct_chk
(
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   // outputs
   input wire logic ir_out,
   input wire logic capture_irq_out,
   input wire logic timeout_out
);
   // --------
   // shadow of the control bytes
   // --------
   logic [7:0] shared, ctl8, ctl16, low_hold;
   logic [3:0] quiet;
   logic want;
   wire logic o8 = ~shared[1];
   wire logic o16 = shared[3] ? shared[2] : ~shared[0];
   wire logic calm = !shared[7] && !ctl8[7] && quiet == 4'hf && (shared[3] || !ctl16[7]);
   // a stop only lands on a prescaler tick, so wait out the slowest divider
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         shared <= 8'h00;
         ctl8 <= 8'h00;
         ctl16 <= 8'h00;
         low_hold <= 8'h00;
         quiet <= 4'h0;
      end
      else
      begin
         if (wr_in && addr_in == `IRDCT_ADDR_SHARED)
            shared <= wdata_in;
         if (wr_in && addr_in == `IRDCT_ADDR_CTL8)
            ctl8 <= wdata_in;
         if (wr_in && addr_in == `IRDCT_ADDR_CTL16)
            ctl16 <= wdata_in;
         if (wr_in && addr_in == `IRDCT_ADDR_LOW)
            low_hold <= wdata_in;
         if (wr_in && addr_in < 8'h03)
            quiet <= 4'h0;
         else if (quiet != 4'hf)
            quiet <= quiet + 4'h1;
      end
   end
   always_comb
   begin
      case (shared[5:4])
         `IRDCT_CMB_AND: want = o8 & o16;
         `IRDCT_CMB_OR: want = o8 | o16;
         `IRDCT_CMB_NOR: want = ~(o8 | o16);
         default: want = ~(o8 & o16);
      endcase
   end
   // --------
   // properties
   // --------
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);
   sequence s_rd_low;
      rd_in && addr_in == `IRDCT_ADDR_LOW;
   endsequence
   sequence s_irq_once;
      capture_irq_out ##1 !capture_irq_out;
   endsequence
   a_held_level: assert property (calm |-> ir_out == want)
      else $error("held output level wrong");
   a_demod_quiet: assert property (shared[7] && quiet == 4'hf |-> !ir_out)
      else $error("output active in demodulation");
   a_read_idle: assert property (rdata_out != 8'h00 |-> $past(rd_in))
      else $error("read data outside read slot");
   a_unmapped_rd: assert property (rd_in && addr_in == 8'h03 |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_hold_back: assert property (s_rd_low |=> rdata_out == low_hold)
      else $error("hold register readback wrong");
   a_irq_gate: assert property (capture_irq_out |-> ctl8[`IRDCT_B_CAPIE] && shared[7])
      else $error("capture event while gated off");
   a_irq_pulse: assert property ($rose(capture_irq_out) |-> s_irq_once)
      else $error("capture event longer than one cycle");
   a_tmo_pulse: assert property (timeout_out |=> !timeout_out)
      else $error("timeout event longer than one cycle");
   a_tmo_tx: assert property (timeout_out |-> !shared[7])
      else $error("timeout event in demodulation");
endmodule // irdct_chk
bind irdct_top irdct_chk u_chk
(
   .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ir_out(ir_out),
   .capture_irq_out(capture_irq_out), .timeout_out(timeout_out)
);
`default_nettype wire

/* File: dv/irdct_ir_source.sv */
`timescale 1ns/1ps
`default_nettype none
module irdct_ir_source
(
   // clock
   input wire logic clk_in,
   // receiver pins
   output logic line_a_out,
   output logic line_b_out
);
   // --------
   // demodulated receiver output, idle low between bursts
   // --------
   initial line_a_out = 1'b0;
   // unselected pin rests at its pull-up
   assign line_b_out = 1'b1;
   task automatic burst(input int hi, input int lo, input int n);
      repeat (n)
      begin
         @(posedge clk_in);
         line_a_out <= 1'b1;
         repeat (hi) @(posedge clk_in);
         line_a_out <= 1'b0;
         repeat (lo) @(posedge clk_in);
      end
   endtask
endmodule // irdct_ir_source
`default_nettype wire

/* File: dv/irdct_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "irdct_consts.vh"
module irdct_top_test;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] rdata_out;
   logic ir_out, capture_irq_out, timeout_out;
   wire demod_a_in, demod_b_in;
   int bad_count = 0;
   int num_checks = 0;
   int irqs = 0;
   int cycles = 0;
   always #2.5 clk_in = ~clk_in;
   irdct_top dut
   (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .demod_a_in(demod_a_in),
      .demod_b_in(demod_b_in), .ir_out(ir_out), .capture_irq_out(capture_irq_out),
      .timeout_out(timeout_out)
   );
   irdct_ir_source u_src (.clk_in(clk_in), .line_a_out(demod_a_in), .line_b_out(demod_b_in));
   // --------
   // helpers
   // --------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_in)
   begin
      cycles++;
      if (capture_irq_out === 1'b1)
         irqs++;
      if (cycles == 10000)
      begin
         bad_count++;
         end_of_test;
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      v = rdata_out;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      check(v & m, e);
   endtask
   // --------
   // scenarios
   // --------
   task automatic t_regs;
      rchk(8'h00, 8'hff, 8'h00);
      rchk(8'h01, 8'hff, 8'h00);
      rchk(8'h03, 8'hff, 8'h00);
      for (int i = 4; i < 8; i++)
      begin
         wr(i[7:0], 8'h5a ^ i[7:0]);
         rchk(i[7:0], 8'hff, 8'h5a ^ i[7:0]);
      end
   endtask
   task automatic t_levels;
      logic a, b, e;
      for (int k = 0; k < 32; k++)
      begin
         wr(8'h01, {2'b00, k[1:0], k[4], k[4] & k[2], k[3], k[2]});
         repeat (20) @(posedge clk_in);
         a = ~k[3];
         b = ~(k[4] ^ k[2]);
         case (k[1:0])
            0: e = a & b;
            1: e = a | b;
            2: e = ~(a | b);
            default: e = ~(a & b);
         endcase
         check(ir_out, {7'h00, e});
      end
   endtask
   task automatic t_start;
      wr(8'h04, 8'h10);
      wr(8'h05, 8'h10);
      wr(8'h01, 8'h1a);
      repeat (20) @(posedge clk_in);
      check(ir_out, 8'h00);
      wr(8'h00, 8'h80);
      repeat (3) @(posedge clk_in);
      #1;
      check(ir_out, 8'h01);
      for (int n = 0; n < 200 && timeout_out !== 1'b1; n++)
      begin
         @(posedge clk_in);
         #1;
      end
      check(timeout_out, 8'h01);
      wr(8'h00, 8'h00);
      repeat (20) @(posedge clk_in);
      rchk(8'h00, 8'ha0, 8'h20);
      check(ir_out, 8'h00);
      wr(8'h00, 8'h38);
      repeat (20) @(posedge clk_in);
      rchk(8'h00, 8'h20, 8'h00);
   endtask
   // wide timer start level, then ping-pong holding the wide timer back
   task automatic t_wide;
      wr(8'h00, 8'h00);
      wr(8'h06, 8'h08);
      wr(8'h07, 8'h00);
      wr(8'h01, 8'h12);
      wr(8'h02, 8'h80);
      repeat (3) @(posedge clk_in);
      #1;
      check(ir_out, 8'h00);
      repeat (9) @(posedge clk_in);
      #1;
      check(ir_out, 8'h01);
      wr(8'h02, 8'h00);
      wr(8'h01, 8'h15);
      wr(8'h02, 8'h80);
      wr(8'h00, 8'h80);
      repeat (8) @(posedge clk_in);
      rchk(8'h0a, 8'h60, 8'h20);
      wr(8'h00, 8'h00);
      wr(8'h02, 8'h00);
   endtask
   task automatic t_demod(input logic [1:0] es, input logic ie, input int n);
      logic [7:0] v, m;
      m = (es == `IRDCT_EDGE_RISE) ? 8'h02 : 8'h01;
      wr(8'h00, 8'h00);
      wr(8'h04, 8'hff);
      wr(8'h05, 8'hff);
      wr(8'h01, {2'b10, es, 4'h3});
      repeat (20) @(posedge clk_in);
      irqs = 0;
      wr(8'h00, {5'h10, ie, 2'h0});
      u_src.burst(10, 30, 2);
      check(irqs[7:0], n[7:0]);
      if (n == 1)
      begin
         rd(m == 8'h02 ? 8'h09 : 8'h08, v);
         check({7'h00, v >= 8'h25 && v <= 8'h2b}, 8'h01);
         rchk(8'h01, m, m);
         wr(8'h00, 8'h00);
         wr(8'h01, {2'b10, es, 4'h0});
         repeat (4) @(posedge clk_in);
         rchk(8'h01, m, m);
         wr(8'h01, {2'b10, es, 4'h3});
         repeat (4) @(posedge clk_in);
         rchk(8'h01, m, 8'h00);
      end
   endtask
   task automatic t_filter(input logic [1:0] f, input int w, input logic pass);
      wr(8'h00, 8'h00);
      wr(8'h01, {2'b10, `IRDCT_EDGE_RISE, f, 2'h3});
      wr(8'h00, 8'h80);
      u_src.burst(w, 20, 1);
      rchk(8'h01, 8'h02, {6'h00, pass, 1'b0});
   endtask
   initial
   begin
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      t_regs;
      t_levels;
      t_start;
      t_wide;
      t_demod(`IRDCT_EDGE_FALL, 1'b1, 1);
      t_demod(`IRDCT_EDGE_RISE, 1'b1, 1);
      t_demod(`IRDCT_EDGE_BOTH, 1'b1, 3);
      t_demod(`IRDCT_EDGE_BOTH, 1'b0, 0);
      t_filter(`IRDCT_FLT_NONE, 2, 1'b1);
      t_filter(`IRDCT_FLT_4, 2, 1'b0);
      t_filter(`IRDCT_FLT_4, 6, 1'b1);
      t_filter(`IRDCT_FLT_8, 5, 1'b0);
      t_filter(`IRDCT_FLT_8, 12, 1'b1);
      end_of_test;
   end
endmodule // irdct_top_test
`default_nettype wire
